// file: asp_alu.sv
// Eight-function ALU with carry forming from the base carry
module asp_alu
  import asp_pkg::*;
(
  asp_dp_if.alu dp
);

  // 17-bit add used by every arithmetic function
  function automatic logic [16:0] add17(input logic [15:0] a, input logic [15:0] b,
                                        input logic cin);
    add17 = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
  endfunction

  logic [16:0] sum;
  logic        msb_carry_out;

  // Only the two-operand functions look at dst
  always_comb begin
    sum = 17'h00000;
    msb_carry_out = 1'b0;
    dp.result = 16'h0000;
    case (dp.op)
      invert_op: begin
        dp.result = ~dp.src;
      end
      twos_complement_op: begin
        sum = add17(~dp.src, 16'h0000, 1'b1);
        dp.result = sum[15:0];
        msb_carry_out = sum[16];
      end
      pass_op: begin
        dp.result = dp.src;
      end
      incr_op: begin
        sum = add17(dp.src, 16'h0000, 1'b1);
        dp.result = sum[15:0];
        msb_carry_out = sum[16];
      end
      add_comp_op: begin
        sum = add17(dp.dst, ~dp.src, 1'b0);
        dp.result = sum[15:0];
        msb_carry_out = sum[16];
      end
      sub_op: begin
        sum = add17(dp.dst, ~dp.src, 1'b1);
        dp.result = sum[15:0];
        msb_carry_out = sum[16];
      end
      add_op: begin
        sum = add17(dp.dst, dp.src, 1'b0);
        dp.result = sum[15:0];
        msb_carry_out = sum[16];
      end
      and_op: begin
        dp.result = dp.dst & dp.src;
      end
      default: begin
        dp.result = dp.src;
      end
    endcase
    // Logical functions never raise a carry out, so the base passes
    dp.alu_carry = dp.base_carry ^ msb_carry_out;
  end

endmodule

// file: asp_dp_if.sv
// Datapath signals between the controller, ALU and shifter
interface asp_dp_if;
  import asp_pkg::*;
  logic [15:0] src;
  logic [15:0] dst;
  asp_op_t     op;
  logic        base_carry;
  logic [15:0] result;
  logic        alu_carry;
  asp_sh_t     sh;
  asp_sk_t     sk;
  logic [15:0] shifted;
  logic        shifted_carry;
  logic        skip;

  modport ctl (output src, dst, op, base_carry, sh, sk,
               input  shifted, shifted_carry, skip);
  modport alu (input  src, dst, op, base_carry,
               output result, alu_carry);
  modport shf (input  result, alu_carry, sh, sk,
               output shifted, shifted_carry, skip);
endinterface

// file: asp_pkg.sv
// Shared constants and types for the ALU, shifter and skip datapath
package asp_pkg;

  // Datapath and bus widths, accumulator count
  localparam int ASP_DW = 16;
  localparam int ASP_AW = 4;
  localparam int ASP_BW = 32;
  localparam int ASP_NACC = 4;

  // ALU function codes
  typedef enum logic [2:0] {
    invert_op          = 3'h0,
    twos_complement_op = 3'h1,
    pass_op            = 3'h2,
    incr_op            = 3'h3,
    add_comp_op        = 3'h4,
    sub_op             = 3'h5,
    add_op             = 3'h6,
    and_op             = 3'h7
  } asp_op_t;

  // Rotate and swap codes
  typedef enum logic [1:0] {
    rot_none  = 2'h0,
    rot_left  = 2'h1,
    rot_right = 2'h2,
    rot_swap  = 2'h3
  } asp_sh_t;

  // Base carry selection codes
  typedef enum logic [1:0] {
    cy_keep   = 2'h0,
    cy_zero   = 2'h1,
    cy_one    = 2'h2,
    cy_invert = 2'h3
  } asp_cy_t;

  // Skip test codes
  typedef enum logic [2:0] {
    test_never          = 3'h0,
    test_always         = 3'h1,
    test_carry_zero     = 3'h2,
    test_carry_set      = 3'h3,
    test_result_zero    = 3'h4,
    test_result_nonzero = 3'h5,
    test_either_zero    = 3'h6,
    test_both_nonzero   = 3'h7
  } asp_sk_t;

  // Instruction field positions, instruction bit 0 is the word LSB
  localparam int IR_CLASS_BIT = 15;
  localparam int IR_SRC_LSB   = 13;
  localparam int IR_DST_LSB   = 11;
  localparam int IR_OP_LSB    = 8;
  localparam int IR_SH_LSB    = 6;
  localparam int IR_CY_LSB    = 4;
  localparam int IR_NL_BIT    = 3;
  localparam int IR_SK_LSB    = 0;

  // Register word indices on the bus
  localparam logic [3:0] REG_INSTR  = 4'h0;
  localparam logic [3:0] REG_CARRY  = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_ACC0   = 4'h4;
  localparam logic [3:0] REG_ACC3   = 4'h7;

  // Status bit positions
  localparam int STAT_SKIP_BIT  = 0;
  localparam int STAT_CLASS_BIT = 1;
  localparam int STAT_STORE_BIT = 2;

  // Reset values
  localparam logic [15:0] ACC_RST   = 16'h0000;
  localparam logic        CARRY_RST = 1'b0;
  localparam logic [15:0] INSTR_RST = 16'h0000;

endpackage

// file: asp_properties.sv
// Port-level checker for the execution unit
module asp_properties
  import asp_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        skip_next,
  input wire logic        exec_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       go_w;
  logic       ex_w;
  logic       lg_w;
  logic [2:0] sk_w;
  logic [3:0] sc_w;
  // Accepted instruction write and its fields; logical ops make carry data-free
  assign go_w = avs_write && !avs_waitrequest && avs_address == REG_INSTR;
  assign ex_w = go_w && avs_writedata[15];
  assign lg_w = ex_w && avs_writedata[10:8] inside {3'h0, 3'h2, 3'h7};
  assign sk_w = avs_writedata[2:0];
  assign sc_w = avs_writedata[7:4];

  exec_done_a: assert property (ex_w |-> ##2 exec_done)
    else $error("no completion pulse");
  never_skip_a: assert property (ex_w && sk_w == 3'h0 |-> ##2 !skip_next)
    else $error("skip with code zero");
  always_skip_a: assert property (ex_w && sk_w == 3'h1 |-> ##2 skip_next)
    else $error("no skip with code one");
  skip_done_a: assert property (skip_next |-> exec_done)
    else $error("skip without execution");
  forced_one_a: assert property (lg_w && sc_w == 4'h2 && sk_w == 3'h3 |-> ##2 skip_next)
    else $error("forced one carry lost");
  forced_zero_a: assert property (lg_w && sc_w == 4'h1 && sk_w == 3'h2 |-> ##2 skip_next)
    else $error("forced zero carry lost");
  swap_carry_a: assert property (lg_w && sc_w == 4'he && sk_w == 3'h2 |-> ##2 !skip_next)
    else $error("swap altered carry");
  class_zero_a: assert property (go_w && !avs_writedata[15] |=> !skip_next [*2])
    else $error("skip from other class");
endmodule

// file: asp_seq_model.sv
// Sequencer stand-in: program counter stepped by each executed instruction
module asp_seq_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        skip_next,
  input  wire logic        exec_done,
  output logic      [15:0] pc_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // A true test steps over the following instruction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_ff <= 16'h0000;
    end else if (exec_done) begin
      pc_ff <= pc_ff + (skip_next ? 16'h0002 : 16'h0001);
    end
  end
endmodule

// file: asp_shift.sv
// 17-bit rotate/swap shifter followed by the skip tester
module asp_shift
  import asp_pkg::*;
(
  asp_dp_if.shf dp
);

  logic zero;

  // Shift the carry:result pair, then test the shifted value
  always_comb begin
    case (dp.sh)
      rot_none: begin
        {dp.shifted_carry, dp.shifted} = {dp.alu_carry, dp.result};
      end
      rot_left: begin
        {dp.shifted_carry, dp.shifted} = {dp.result, dp.alu_carry};
      end
      rot_right: begin
        {dp.shifted, dp.shifted_carry} = {dp.alu_carry, dp.result};
      end
      rot_swap: begin
        dp.shifted = {dp.result[7:0], dp.result[15:8]};
        dp.shifted_carry = dp.alu_carry;
      end
      default: begin
        {dp.shifted_carry, dp.shifted} = {dp.alu_carry, dp.result};
      end
    endcase
    zero = (dp.shifted == 16'h0000);
    case (dp.sk)
      test_never:          dp.skip = 1'b0;
      test_always:         dp.skip = 1'b1;
      test_carry_zero:     dp.skip = ~dp.shifted_carry;
      test_carry_set:      dp.skip = dp.shifted_carry;
      test_result_zero:    dp.skip = zero;
      test_result_nonzero: dp.skip = ~zero;
      test_either_zero:    dp.skip = ~dp.shifted_carry | zero;
      test_both_nonzero:   dp.skip = dp.shifted_carry & ~zero;
      default:             dp.skip = 1'b0;
    endcase
  end

endmodule

// file: asp_top.sv
// Arithmetic/logical execution unit with accumulators behind an Avalon-MM slave
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
module asp_top
  import asp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             skip_next,
  output logic             exec_done
);

  // Bus phases: idle, answering, executing a written instruction
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_ACK  = 2'h1,
    PH_EXEC = 2'h2
  } asp_phase_t;

  typedef struct packed {
    asp_phase_t       phase;
    logic             waitreq;
    logic [31:0]      rdata;
    logic [15:0]      instr;
    logic [3:0][15:0] acc;
    logic             carry;
    logic             skip;
    logic             class_err;
    logic             stored;
    logic             skip_pulse;
    logic             done_pulse;
  } asp_state_t;

  asp_state_t st_ff;
  asp_state_t nxt_st;

  asp_dp_if dp ();

  asp_alu u_alu (
    .dp (dp.alu)
  );

  asp_shift u_shift (
    .dp (dp.shf)
  );

  // Byte-lane merge for the 16-bit registers; upper lanes have no storage
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  be);
    merge16[7:0]  = be[0] ? wdata[7:0]  : old[7:0];
    merge16[15:8] = be[1] ? wdata[15:8] : old[15:8];
  endfunction

  // Word addresses that land in the accumulator file; shared by read and write paths
  function automatic logic is_acc_word(input logic [3:0] addr);
    is_acc_word = (addr >= REG_ACC0) && (addr <= REG_ACC3);
  endfunction

  // Base carry chosen from the carry flag by the carry field
  function automatic logic base_carry_sel(input asp_cy_t cy, input logic flag);
    case (cy)
      cy_keep:   base_carry_sel = flag;
      cy_zero:   base_carry_sel = 1'b0;
      cy_one:    base_carry_sel = 1'b1;
      cy_invert: base_carry_sel = ~flag;
      default:   base_carry_sel = flag;
    endcase
  endfunction

  // Instruction field decode into the datapath
  logic [1:0] src_sel;
  logic [1:0] dst_sel;
  logic       no_store_bit;
  logic       is_alu_class;

  always_comb begin
    src_sel      = st_ff.instr[IR_SRC_LSB +: 2];
    dst_sel      = st_ff.instr[IR_DST_LSB +: 2];
    no_store_bit = st_ff.instr[IR_NL_BIT];
    is_alu_class = st_ff.instr[IR_CLASS_BIT];
    dp.src        = st_ff.acc[src_sel];
    dp.dst        = st_ff.acc[dst_sel];
    dp.op         = asp_op_t'(st_ff.instr[IR_OP_LSB +: 3]);
    dp.sh         = asp_sh_t'(st_ff.instr[IR_SH_LSB +: 2]);
    dp.sk         = asp_sk_t'(st_ff.instr[IR_SK_LSB +: 3]);
    dp.base_carry = base_carry_sel(asp_cy_t'(st_ff.instr[IR_CY_LSB +: 2]), st_ff.carry);
  end

  // Read mux; unmapped words and reserved bits read as zero
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h00000000;
    case (avs_address)
      REG_INSTR:  rd_word = {16'h0000, st_ff.instr};
      REG_CARRY:  rd_word = {31'h00000000, st_ff.carry};
      REG_STATUS: begin
        rd_word[STAT_SKIP_BIT]  = st_ff.skip;
        rd_word[STAT_CLASS_BIT] = st_ff.class_err;
        rd_word[STAT_STORE_BIT] = st_ff.stored;
      end
      default: begin
        if (is_acc_word(avs_address)) begin
          rd_word = {16'h0000, st_ff.acc[avs_address[1:0]]};
        end
      end
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.skip_pulse = 1'b0;
    nxt_st.done_pulse = 1'b0;
    case (st_ff.phase)
      PH_IDLE: begin
        // One wait cycle gives the read mux a register stage
        if (avs_read || avs_write) begin
          nxt_st.waitreq = 1'b0;
          nxt_st.rdata   = avs_read ? rd_word : 32'h00000000;
          nxt_st.phase   = PH_ACK;
        end
      end
      PH_ACK: begin
        nxt_st.waitreq = 1'b1;
        nxt_st.phase   = PH_IDLE;
        if (avs_write) begin
          case (avs_address)
            REG_INSTR: begin
              nxt_st.instr = merge16(st_ff.instr, avs_writedata, avs_byteenable);
              nxt_st.phase = PH_EXEC;
            end
            REG_CARRY: begin
              if (avs_byteenable[0]) begin
                nxt_st.carry = avs_writedata[0];
              end
            end
            default: begin
              if (is_acc_word(avs_address)) begin
                nxt_st.acc[avs_address[1:0]] =
                  merge16(st_ff.acc[avs_address[1:0]], avs_writedata, avs_byteenable);
              end
            end
          endcase
        end
      end
      PH_EXEC: begin
        // Bus stays stalled here, so operands cannot change mid-instruction
        nxt_st.phase      = PH_IDLE;
        nxt_st.done_pulse = 1'b1;
        nxt_st.class_err  = ~is_alu_class;
        nxt_st.stored     = 1'b0;
        nxt_st.skip       = 1'b0;
        if (is_alu_class) begin
          if (!no_store_bit) begin
            nxt_st.acc[dst_sel] = dp.shifted;
            nxt_st.carry        = dp.shifted_carry;
            nxt_st.stored       = 1'b1;
          end
          nxt_st.skip       = dp.skip;
          nxt_st.skip_pulse = dp.skip;
        end
      end
      default: begin
        nxt_st.phase   = PH_IDLE;
        nxt_st.waitreq = 1'b1;
      end
    endcase
  end

  // State register with constant reset values
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff.phase      <= PH_IDLE;
      st_ff.waitreq    <= 1'b1;
      st_ff.rdata      <= 32'h00000000;
      st_ff.instr      <= INSTR_RST;
      st_ff.acc        <= {ASP_NACC{ACC_RST}};
      st_ff.carry      <= CARRY_RST;
      st_ff.skip       <= 1'b0;
      st_ff.class_err  <= 1'b0;
      st_ff.stored     <= 1'b0;
      st_ff.skip_pulse <= 1'b0;
      st_ff.done_pulse <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitreq;
  assign skip_next       = st_ff.skip_pulse;
  assign exec_done       = st_ff.done_pulse;

endmodule

// file: asp_top_tb.sv
// Self-checking bench for the execution unit
module asp_top_tb
  import asp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        skip_next;
  logic        exec_done;
  logic [15:0] pc_ff;
  logic [15:0] acc_m [4];
  logic        cy_m;
  logic [15:0] pc_exp = 16'h0;
  logic [31:0] rdq [$];
  logic        skq [$];
  integer      seed = 84;
  int          n_fail = 0;
  int          tests_run = 0;

  asp_top dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .skip_next(skip_next),
    .exec_done(exec_done));
  asp_seq_model seq (.sys_clk(sys_clk), .rst(rst), .skip_next(skip_next),
    .exec_done(exec_done), .pc_ff(pc_ff));

  // 200 MHz clock
  initial forever #2.5 sys_clk = ~sys_clk;

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t skip %b expected %b", $time, got, exp);
    end
  endtask

  // One bus access; idle edge first so no signal is driven twice in a step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) cmp_bit(1'b0, 1'b1);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // Model follows the byte lanes that the bench itself drives
    if (wr && a[3:2] == 2'h1) begin
      if (avs_byteenable[0]) acc_m[a[1:0]][7:0] = d[7:0];
      if (avs_byteenable[1]) acc_m[a[1:0]][15:8] = d[15:8];
    end
    if (wr && a == REG_CARRY && avs_byteenable[0]) cy_m = d[0];
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rdq.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  // Reference execution, then the write and read-back of its effects
  task automatic run(input logic [15:0] ins);
    logic [15:0] s, d, r;
    logic        b, c, k;
    logic [16:0] v;
    logic [7:0]  t;
    s = acc_m[ins[14:13]];
    d = acc_m[ins[12:11]];
    b = ins[5] ? (ins[4] ? !cy_m : 1'b1) : (ins[4] ? 1'b0 : cy_m);
    case (ins[10:8])
      3'h0: v = {1'b0, ~s};
      3'h1: v = {1'b0, ~s} + 17'h1;
      3'h2: v = {1'b0, s};
      3'h3: v = {1'b0, s} + 17'h1;
      3'h4: v = {1'b0, d} + {1'b0, ~s};
      3'h5: v = {1'b0, d} + {1'b0, ~s} + 17'h1;
      3'h6: v = {1'b0, d} + {1'b0, s};
      default: v = {1'b0, s & d};
    endcase
    c = b ^ v[16];
    r = v[15:0];
    case (ins[7:6])
      2'h1: {c, r} = {r, c};
      2'h2: {r, c} = {c, r};
      2'h3: r = {r[7:0], r[15:8]};
      default: ;
    endcase
    t = {c && r != 0, !c || r == 0, r != 0, r == 0, c, !c, 1'b1, 1'b0};
    k = t[ins[2:0]];
    skq.push_back(k);
    pc_exp += 16'h1 + k;
    bus(1'b1, REG_INSTR, {16'h0, ins});
    if (!ins[3]) begin
      acc_m[ins[12:11]] = r;
      cy_m = c;
    end
    rd({2'h1, ins[12:11]}, {16'h0, acc_m[ins[12:11]]});
    rd(REG_CARRY, {31'h0, cy_m});
    rd(REG_STATUS, {29'h0, !ins[3], 1'b0, k});
  endtask

  // Results are matched against the oldest expectation as they appear
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && rdq.size() > 0)
      cmp_word(avs_readdata, rdq.pop_front());
    if (exec_done === 1'b1 && skq.size() > 0)
      cmp_bit(skip_next, skq.pop_front());
  end

  task automatic wrap_up;
    if (rdq.size() + skq.size() != 0) cmp_bit(1'b0, 1'b1);
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog sized well above the roughly 28k cycles of traffic
  initial begin
    repeat (90000) @(posedge sys_clk);
    $display("CHECK FAILED t=%0t run timed out", $time);
    n_fail++;
    wrap_up;
  end

  // Every opcode, shift, carry select and skip code, on random and edge data
  initial begin
    logic [15:0] v;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 1024; i++) begin
      for (int a = 4; a < 8; a++) begin
        v = 16'($random(seed));
        if (v[2:1] == 2'h0) v = {16{v[0]}};
        bus(1'b1, a[3:0], {16'h0, v});
      end
      bus(1'b1, REG_CARRY, $random(seed));
      v = 16'($random(seed));
      run({1'b1, v[14:11], i[2:0], i[4:3], i[9:8], v[3], i[7:5]});
    end
    cmp_word({16'h0, pc_ff}, {16'h0, pc_exp});
    bus(1'b1, REG_INSTR, 32'h0000_7fff);
    rd(REG_STATUS, 32'h2);
    rd(REG_ACC0, {16'h0, acc_m[0]});
    bus(1'b1, REG_STATUS, 32'hffff_ffff);
    rd(REG_STATUS, 32'h2);
    bus(1'b1, 4'h3, 32'hffff_ffff);
    rd(4'h3, 32'h0);
    rd(4'hf, 32'h0);
    // Partial byte lanes: only enabled halves change, carry needs lane 0
    avs_byteenable <= 4'h1;
    bus(1'b1, REG_ACC0, 32'h0000_a55a);
    avs_byteenable <= 4'h2;
    bus(1'b1, 4'h5, 32'h0000_c33c);
    avs_byteenable <= 4'he;
    bus(1'b1, REG_CARRY, {31'h0, !cy_m});
    avs_byteenable <= 4'hf;
    rd(REG_ACC0, {16'h0, acc_m[0]});
    rd(4'h5, {16'h0, acc_m[1]});
    rd(REG_CARRY, {31'h0, cy_m});
    repeat (4) @(posedge sys_clk);
    wrap_up;
  end
endmodule

bind asp_top asp_properties u_props (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .skip_next(skip_next), .exec_done(exec_done));
